// ### shared/dbg_mode_regs.svh
// register layout, field positions and timing counts of the debug-mode control block
//
// Summary of operation
// - debug mode stops fetch unless debugger executes
// - system clock runs except in stop
// - enabled peripherals run except in stop
// - entering debug mode leaves halt automatically
// - watchdog refreshed constantly in debug mode
// - host writing flag one enters debug
// - enabled breakpoint instruction enters debug mode
// - debug pin low at reset exit enters
// - flag cleared, power-on or brownout exits
// - loop bit selects flag set or looping
// - self-reset bit one resets whole device
// - debugger logic survives the self-reset
// - self-reset bit clears when reset finishes
// - status bit 7 set in debug mode
// - status bit 7 set after breakpoint since write
// - status bit 6 shows halt state
// - status bit 5 shows read protect enabled
// - status reserved low bits read zero
`ifndef DBG_MODE_REGS_SVH
`define DBG_MODE_REGS_SVH

`define CTL_DBG_MODE_BIT   7
`define CTL_BRK_EN_BIT     6
`define CTL_BRK_LOOP_BIT   5
`define CTL_SELF_RST_BIT   0
`define CTL_RESET_VAL      8'h00

`define STAT_IDLE_BIT      7
`define STAT_HALT_BIT      6
`define STAT_RPROT_BIT     5
`define STAT_RSVD_VAL      5'h00
`define STAT_RESET_VAL     8'h00

`define SRST_HOLD_CYCLES   3'h4
`define PIN_SETTLE_CYCLES  2'h2

`endif

// ### shared/dbg_mode_pkg.sv
// types shared by the debug-mode control block
package dbg_mode_pkg;
    typedef enum logic [1:0] {
        SRST_IDLE,
        SRST_HOLD,
        SRST_DONE
    } srst_state_e;
    typedef logic [7:0] byte_t;
endpackage

// ### shared/srst_if.sv
// handshake between the control logic and the self-reset sequencer
`timescale 1ns/100ps
interface srst_if;
    logic start;
    logic done;
    logic sys_rst;
    modport ctl (output start, input done, input sys_rst);
    modport seq (input start, output done, output sys_rst);
endinterface

// ### src/pin_sync2.sv
// two-stage synchroniser for an asynchronous pin
`timescale 1ns/100ps
module pin_sync2 (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // pin idles high, so reset to high to avoid a false low sample
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            dout   <= 1'b1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ### src/self_reset_seq.sv
// holds the device-wide reset for a fixed count, then reports completion
`timescale 1ns/100ps
`include "dbg_mode_regs.svh"
module self_reset_seq (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    srst_if.seq       sif
);
    dbg_mode_pkg::srst_state_e state_q;
    dbg_mode_pkg::srst_state_e state_d;
    logic [2:0]                cnt_q;
    logic [2:0]                cnt_d;
    logic                      hold_end;

    assign hold_end = (cnt_q == `SRST_HOLD_CYCLES - 3'h1);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            dbg_mode_pkg::SRST_IDLE: begin
                cnt_d = 3'h0;
                if (sif.start) begin
                    state_d = dbg_mode_pkg::SRST_HOLD;
                end
            end
            dbg_mode_pkg::SRST_HOLD: begin
                cnt_d = cnt_q + 3'h1;
                if (hold_end) begin
                    state_d = dbg_mode_pkg::SRST_DONE;
                end
            end
            dbg_mode_pkg::SRST_DONE: begin
                state_d = dbg_mode_pkg::SRST_IDLE;
            end
            default: state_d = dbg_mode_pkg::SRST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= dbg_mode_pkg::SRST_IDLE;
            cnt_q       <= 3'h0;
            sif.sys_rst <= 1'b0;
            sif.done    <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            sif.sys_rst <= (state_d == dbg_mode_pkg::SRST_HOLD);
            sif.done    <= (state_d == dbg_mode_pkg::SRST_DONE);
        end
    end
endmodule

// ### src/debug_mode_ctrl.sv
// debug-mode entry, exit, core steering, self-reset and status of the on-chip debugger
`timescale 1ns/100ps
`include "dbg_mode_regs.svh"
module debug_mode_ctrl (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       debug_pin_n,
    input  wire logic       ctl_wr_en,
    input  wire logic [7:0] ctl_wr_data,
    input  wire logic       dbg_exec_req,
    input  wire logic       breakpoint_instr,
    input  wire logic       halt_active,
    input  wire logic       stop_active,
    input  wire logic       wdt_enabled,
    input  wire logic       read_protect_opt_n,
    output logic [7:0]      ctl_rd_data,
    output logic [7:0]      stat_rd_data,
    output logic            cpu_fetch_stop,
    output logic            cpu_brk_loop,
    output logic            halt_exit,
    output logic            wdt_refresh,
    output logic            clk_run,
    output logic            periph_run,
    output logic            sys_reset
);
    srst_if sif ();

    logic       pin_s;
    logic       debug_mode_flag_q;
    logic       debug_mode_flag_d;
    logic       brk_en_q;
    logic       brk_loop_q;
    logic       self_rst_q;
    logic       self_rst_d;
    logic       brk_seen_q;
    logic       brk_seen_d;
    logic       samp_pend_q;
    logic [1:0] samp_cnt_q;
    logic [1:0] samp_cnt_d;
    logic       samp_now;
    logic       pin_enter;
    logic       brk_hit;
    logic       brk_to_flag;
    logic       enter_evt;
    logic       wr_flag;
    logic       srst_start_q;
    logic       srst_start;
    logic       idle_d;
    logic       cpu_fetch_stop_d;
    logic       wdt_refresh_d;
    logic       halt_exit_d;

    pin_sync2 u_pin_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (debug_pin_n),
        .dout    (pin_s)
    );

    // arst_n is the power-on / brownout reset only; the self-reset never reaches here
    self_reset_seq u_srst (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sif     (sif.seq)
    );

    // pin is sampled once its synchroniser has settled after each reset exit
    assign samp_now   = samp_pend_q && (samp_cnt_q == `PIN_SETTLE_CYCLES);
    assign samp_cnt_d = samp_now ? 2'h0 : samp_cnt_q + {1'b0, samp_pend_q};
    assign pin_enter  = samp_now && !pin_s;

    assign brk_hit     = breakpoint_instr && brk_en_q;
    assign brk_to_flag = brk_hit && !brk_loop_q;
    assign enter_evt   = pin_enter || brk_to_flag;
    assign wr_flag     = ctl_wr_data[`CTL_DBG_MODE_BIT];

    // an entry event in the same cycle as a clearing write still wins
    assign debug_mode_flag_d = enter_evt ? 1'b1 :
                               ctl_wr_en ? wr_flag : debug_mode_flag_q;

    assign brk_seen_d = brk_hit ? 1'b1 : (ctl_wr_en ? 1'b0 : brk_seen_q);

    // writing zero to the self-reset bit does nothing; a request while one is still pending is ignored
    assign srst_start = ctl_wr_en && ctl_wr_data[`CTL_SELF_RST_BIT] && !self_rst_q;
    assign self_rst_d = srst_start ? 1'b1 : (sif.done ? 1'b0 : self_rst_q);

    assign idle_d           = debug_mode_flag_d || brk_seen_d;
    assign cpu_fetch_stop_d = debug_mode_flag_d && !dbg_exec_req;
    assign halt_exit_d      = debug_mode_flag_d && halt_active;
    assign wdt_refresh_d    = debug_mode_flag_d && wdt_enabled;

    assign sif.start = srst_start_q;
    assign sys_reset = sif.sys_rst;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            debug_mode_flag_q <= 1'b0;
            brk_en_q          <= 1'b0;
            brk_loop_q        <= 1'b0;
            self_rst_q        <= 1'b0;
            brk_seen_q        <= 1'b0;
            srst_start_q      <= 1'b0;
        end else begin
            debug_mode_flag_q <= debug_mode_flag_d;
            self_rst_q        <= self_rst_d;
            brk_seen_q        <= brk_seen_d;
            srst_start_q      <= srst_start;
            if (ctl_wr_en) begin
                brk_en_q   <= ctl_wr_data[`CTL_BRK_EN_BIT];
                brk_loop_q <= ctl_wr_data[`CTL_BRK_LOOP_BIT];
            end
        end
    end

    // reset exit sampling restarts after a self-reset, since the device leaves reset again
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            samp_pend_q <= 1'b1;
            samp_cnt_q  <= 2'h0;
        end else begin
            samp_pend_q <= sif.done || (samp_pend_q && !samp_now);
            samp_cnt_q  <= sif.done ? 2'h0 : samp_cnt_d;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cpu_fetch_stop <= 1'b0;
            cpu_brk_loop   <= 1'b0;
            halt_exit      <= 1'b0;
            wdt_refresh    <= 1'b0;
            clk_run        <= 1'b1;
            periph_run     <= 1'b1;
        end else begin
            cpu_fetch_stop <= cpu_fetch_stop_d;
            cpu_brk_loop   <= brk_en_q && brk_loop_q;
            halt_exit      <= halt_exit_d;
            wdt_refresh    <= wdt_refresh_d;
            clk_run        <= !stop_active;
            periph_run     <= !stop_active;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl_rd_data  <= `CTL_RESET_VAL;
            stat_rd_data <= `STAT_RESET_VAL;
        end else begin
            ctl_rd_data  <= {debug_mode_flag_d, brk_en_q, brk_loop_q, 4'h0, self_rst_d};
            stat_rd_data <= {idle_d,
                             halt_active,
                             !read_protect_opt_n,
                             `STAT_RSVD_VAL};
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // a control write in the same cycle may clear the flag, so it is left out here
    fetch_stop_a: assert property (
        debug_mode_flag_q && !dbg_exec_req && !ctl_wr_en |=> cpu_fetch_stop)
        else $error("fetch not stopped in debug mode");

    clk_stop_a: assert property (
        stop_active |=> !clk_run && !periph_run)
        else $error("clock or peripherals running in stop");

    clk_run_a: assert property (
        !stop_active |=> clk_run && periph_run)
        else $error("clock or peripherals stopped outside stop");

    halt_leave_a: assert property (
        debug_mode_flag_q && halt_active && !ctl_wr_en |=> halt_exit)
        else $error("halt not left in debug mode");

    wdt_kick_a: assert property (
        wdt_enabled && debug_mode_flag_q && !ctl_wr_en |=> wdt_refresh)
        else $error("watchdog not refreshed in debug mode");

    // back-to-back writes are legal, so look only at the cycle right after the write
    host_enter_a: assert property (
        ctl_wr_en && ctl_wr_data[`CTL_DBG_MODE_BIT] |=> debug_mode_flag_q && stat_rd_data[7])
        else $error("host write did not enter debug mode");

    brk_enter_a: assert property (
        breakpoint_instr && brk_en_q && !brk_loop_q |=> debug_mode_flag_q)
        else $error("breakpoint did not enter debug mode");

    pin_enter_a: assert property (
        samp_now && !pin_s |=> debug_mode_flag_q)
        else $error("debug pin low at reset exit ignored");

    flag_exit_a: assert property (
        ctl_wr_en && !wr_flag && !enter_evt |=> !debug_mode_flag_q && !cpu_fetch_stop)
        else $error("clearing the flag did not exit");

    brk_loop_a: assert property (
        breakpoint_instr && brk_en_q && brk_loop_q && !debug_mode_flag_q && !pin_enter
        && !ctl_wr_en |=> !debug_mode_flag_q && cpu_brk_loop)
        else $error("loop mode breakpoint set the flag");

    self_rst_a: assert property (
        srst_start |=> ##1 sys_reset [*4] ##1 !sys_reset)
        else $error("self-reset pulse wrong length");

    keep_flag_a: assert property (
        sys_reset && debug_mode_flag_q && !ctl_wr_en |=> debug_mode_flag_q)
        else $error("debug flag lost during self-reset");

    rst_clear_a: assert property (
        sif.done |=> !self_rst_q && !ctl_rd_data[`CTL_SELF_RST_BIT])
        else $error("self-reset bit not cleared");

    // status and flag register on the same edge, so a set flag must show in the idle bit every cycle
    idle_bit_a: assert property (
        debug_mode_flag_q |-> stat_rd_data[`STAT_IDLE_BIT])
        else $error("idle bit low in debug mode");

    brk_seen_a: assert property (
        brk_hit |=> stat_rd_data[`STAT_IDLE_BIT] && brk_seen_q)
        else $error("breakpoint not shown in status");

    halt_bit_a: assert property (
        1'b1 |=> stat_rd_data[`STAT_HALT_BIT] == $past(halt_active))
        else $error("halt status wrong");

    rprot_bit_a: assert property (
        1'b1 |=> stat_rd_data[`STAT_RPROT_BIT] == !$past(read_protect_opt_n))
        else $error("read protect status wrong");

    rsvd_zero_a: assert property (
        stat_rd_data[4:0] == `STAT_RSVD_VAL)
        else $error("status reserved bits not zero");

    flag_shown_a: assert property (
        enter_evt |=> ctl_rd_data[`CTL_DBG_MODE_BIT])
        else $error("entry did not raise the flag");

    pin_entry_c: cover property (samp_now && !pin_s);
    brk_entry_c: cover property (brk_to_flag ##[1:20] ctl_wr_en && !wr_flag);
    self_rst_c: cover property (srst_start ##[1:10] sif.done);
    loop_c: cover property (brk_hit && brk_loop_q);
endmodule

// ### test/debug_host_model.sv
// debug host stand-in: drives the debug pin and control register writes
`timescale 1ns/100ps
module debug_host_model (
    input  wire logic       clk_sys,
    output logic            debug_pin_n,
    output logic            ctl_wr_en,
    output logic [7:0]      ctl_wr_data
);
    initial begin
        debug_pin_n = 1'b1;
        ctl_wr_en   = 1'b0;
        ctl_wr_data = 8'h00;
    end

    // called just after a rising edge; the write is taken at the next edge
    task automatic write_ctl(input logic [7:0] d);
        ctl_wr_data = d & 8'he1;
        ctl_wr_en   = 1'b1;
        @(posedge clk_sys);
        #1;
        ctl_wr_en   = 1'b0;
        // stale data must not look valid once the strobe is gone
        ctl_wr_data = ~ctl_wr_data;
    endtask

    task automatic set_pin(input logic lvl);
        debug_pin_n = lvl;
    endtask
endmodule

// ### test/debug_mode_control_status_tb.sv
// self-checking bench for the debug-mode control block
`timescale 1ns/100ps
`include "dbg_mode_regs.svh"
module debug_mode_control_status_tb;
    logic                clk_sys;
    logic                arst_n;
    logic                debug_pin_n;
    logic                ctl_wr_en;
    logic [7:0]          ctl_wr_data;
    logic                dbg_exec_req;
    logic                breakpoint_instr;
    logic                halt_active;
    logic                stop_active;
    logic                wdt_enabled;
    logic                read_protect_opt_n;
    dbg_mode_pkg::byte_t ctl_rd_data;
    dbg_mode_pkg::byte_t stat_rd_data;
    logic                cpu_fetch_stop;
    logic                cpu_brk_loop;
    logic                halt_exit;
    logic                wdt_refresh;
    logic                clk_run;
    logic                periph_run;
    logic                sys_reset;
    int                  mismatches = 0;
    int                  n_tests = 0;
    int                  cycles = 0;

    always #25 clk_sys = ~clk_sys;

    debug_host_model debug_host_model_inst (
        .clk_sys     (clk_sys),
        .debug_pin_n (debug_pin_n),
        .ctl_wr_en   (ctl_wr_en),
        .ctl_wr_data (ctl_wr_data)
    );

    debug_mode_ctrl debug_mode_ctrl_inst (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .debug_pin_n        (debug_pin_n),
        .ctl_wr_en          (ctl_wr_en),
        .ctl_wr_data        (ctl_wr_data),
        .dbg_exec_req       (dbg_exec_req),
        .breakpoint_instr   (breakpoint_instr),
        .halt_active        (halt_active),
        .stop_active        (stop_active),
        .wdt_enabled        (wdt_enabled),
        .read_protect_opt_n (read_protect_opt_n),
        .ctl_rd_data        (ctl_rd_data),
        .stat_rd_data       (stat_rd_data),
        .cpu_fetch_stop     (cpu_fetch_stop),
        .cpu_brk_loop       (cpu_brk_loop),
        .halt_exit          (halt_exit),
        .wdt_refresh        (wdt_refresh),
        .clk_run            (clk_run),
        .periph_run         (periph_run),
        .sys_reset          (sys_reset)
    );

    task automatic stop_test();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a hang costs a mismatch rather than a silent stall
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check8(input dbg_mode_pkg::byte_t got, input dbg_mode_pkg::byte_t exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic do_reset(input logic pin);
        debug_host_model_inst.set_pin(pin);
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        step(8);
    endtask

    task automatic pulse_brk();
        breakpoint_instr = 1'b1;
        step(1);
        breakpoint_instr = 1'b0;
        step(2);
    endtask

    task automatic test_reset_values();
        do_reset(1'b1);
        check8(ctl_rd_data, `CTL_RESET_VAL);
        check8(stat_rd_data, `STAT_RESET_VAL);
        check1(clk_run, 1'b1);
        check1(periph_run, 1'b1);
        check1(cpu_fetch_stop, 1'b0);
    endtask

    task automatic test_pin_entry();
        do_reset(1'b0);
        debug_host_model_inst.set_pin(1'b1);
        check1(ctl_rd_data[`CTL_DBG_MODE_BIT], 1'b1);
        check1(stat_rd_data[`STAT_IDLE_BIT], 1'b1);
        check1(cpu_fetch_stop, 1'b1);
        debug_host_model_inst.write_ctl(8'h00);
        step(2);
        check1(ctl_rd_data[`CTL_DBG_MODE_BIT], 1'b0);
        check1(cpu_fetch_stop, 1'b0);
    endtask

    task automatic test_debug_steering();
        debug_host_model_inst.write_ctl(8'h80);
        halt_active = 1'b1;
        wdt_enabled = 1'b1;
        step(2);
        check1(halt_exit, 1'b1);
        check1(wdt_refresh, 1'b1);
        check8(stat_rd_data, 8'hc0);
        dbg_exec_req = 1'b1;
        step(2);
        check1(cpu_fetch_stop, 1'b0);
        stop_active = 1'b1;
        step(2);
        check1(clk_run, 1'b0);
        check1(periph_run, 1'b0);
        dbg_exec_req = 1'b0;
        stop_active = 1'b0;
        debug_host_model_inst.write_ctl(8'h00);
        step(2);
        check1(halt_exit, 1'b0);
        check1(wdt_refresh, 1'b0);
        check1(clk_run, 1'b1);
        halt_active = 1'b0;
        wdt_enabled = 1'b0;
        step(2);
        check1(stat_rd_data[`STAT_HALT_BIT], 1'b0);
    endtask

    task automatic test_breakpoints();
        pulse_brk();
        check8(stat_rd_data, 8'h00);
        debug_host_model_inst.write_ctl(8'h40);
        pulse_brk();
        check1(ctl_rd_data[`CTL_DBG_MODE_BIT], 1'b1);
        check1(stat_rd_data[`STAT_IDLE_BIT], 1'b1);
        debug_host_model_inst.write_ctl(8'h60);
        step(2);
        check1(cpu_brk_loop, 1'b1);
        check1(stat_rd_data[`STAT_IDLE_BIT], 1'b0);
        pulse_brk();
        check1(ctl_rd_data[`CTL_DBG_MODE_BIT], 1'b0);
        check1(stat_rd_data[`STAT_IDLE_BIT], 1'b1);
        debug_host_model_inst.write_ctl(8'h00);
        step(2);
        check1(stat_rd_data[`STAT_IDLE_BIT], 1'b0);
        check1(cpu_brk_loop, 1'b0);
    endtask

    task automatic test_self_reset();
        int hi;
        int w;
        hi = 0;
        w = 0;
        debug_host_model_inst.write_ctl(8'h81);
        while (sys_reset !== 1'b1 && w < 6) begin
            step(1);
            w++;
        end
        while (sys_reset === 1'b1 && hi < 12) begin
            step(1);
            hi++;
        end
        check8(hi[7:0], {5'h00, `SRST_HOLD_CYCLES});
        step(3);
        check1(ctl_rd_data[`CTL_SELF_RST_BIT], 1'b0);
        check1(ctl_rd_data[`CTL_DBG_MODE_BIT], 1'b1);
        debug_host_model_inst.write_ctl(8'h80);
        step(6);
        check1(sys_reset, 1'b0);
    endtask

    task automatic test_protect_and_por();
        read_protect_opt_n = 1'b0;
        step(2);
        check8(stat_rd_data, 8'ha0);
        read_protect_opt_n = 1'b1;
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        step(6);
        check8(ctl_rd_data, `CTL_RESET_VAL);
        check1(stat_rd_data[`STAT_RPROT_BIT], 1'b0);
    endtask

    initial begin
        clk_sys            = 1'b0;
        arst_n             = 1'b0;
        dbg_exec_req       = 1'b0;
        breakpoint_instr   = 1'b0;
        halt_active        = 1'b0;
        stop_active        = 1'b0;
        wdt_enabled        = 1'b0;
        read_protect_opt_n = 1'b1;
        test_reset_values();
        test_pin_entry();
        test_debug_steering();
        test_breakpoints();
        test_self_reset();
        test_protect_and_por();
        stop_test();
    end
endmodule
